//--- verif/serial_readback_status_tb.sv
// Bench: APB drives the host end, which talks to the device end over the link.
// Assumes one 25 MHz clock for both ends and the host register map of srb_pkg.
`timescale 1ns/1ps
module serial_readback_status_tb;
  localparam int HALF = 6;
  localparam logic [1:0] ADDR = 2'h1;
  localparam logic [15:0] DCDC = 16'h6A5C;
  logic clk_i, reset_i, psel, penable, pwrite, pslverr, pready;
  logic otemp, echo, crc_err, fault, fault_oe, crc_e, err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [srb_pkg::NUM_CH_REGS-1:0][15:0] regs;
  logic [15:0] main_ctrl, status;
  logic [3:0] cmode, bfail, ifault, vfault, slew;
  int checked, miscompares;

  srb_link_if link_i();
  srb_host_end #(.SCLK_HALF(HALF)) srb_host_end_i (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .link(link_i));
  srb_dev_end srb_dev_end_i (.clk_i(clk_i), .reset_i(reset_i), .link(link_i), .dev_addr_i(ADDR),
    .regs_i(regs), .main_ctrl_i(main_ctrl), .dcdc_ctrl_i(DCDC), .current_mode_i(cmode),
    .boost_fail_i(bfail), .iout_fault_i(ifault), .vout_fault_i(vfault), .ramp_slewing_i(slew),
    .overtemp_i(otemp), .user_echo_i(echo), .status_o(status), .crc_err_o(crc_err), .fault_o(fault),
    .fault_oe_o(fault_oe));
  srb_link_asserts #(.SCLK_HALF(HALF)) srb_link_asserts_i (.clk_i(clk_i), .reset_i(reset_i),
    .sclk(link_i.sclk), .sync_n(link_i.sync_n), .sdin(link_i.sdin), .sdo(link_i.sdo));

  function automatic logic [7:0] tb_crc(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? srb_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  function automatic logic [15:0] exp_st();
    logic [3:0] en;
    for (int i = 0; i < 4; i++) begin
      en[i] = regs[20 + i][srb_pkg::RAMP_EN_BIT];
    end
    return {bfail, echo, crc_e, |(slew & en), otemp, vfault, ifault | (cmode & bfail)};
  endfunction

  function automatic logic [15:0] exp_reg(input int s);
    case (s)
      24: return exp_st();
      25: return main_ctrl;
      26: return DCDC;
      default: return regs[s];
    endcase
  endfunction

  // Low bits set on purpose: they must not matter
  function automatic logic [23:0] req(input logic [1:0] a, input logic [4:0] s);
    return {1'b1, a, s, 16'hA5C3};
  endfunction

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  // One frame, then the received bits land in rd
  task automatic frame(input logic [23:0] w, input logic packet_crc_check);
    int n;
    apb(1'b1, srb_pkg::OFS_TX, {8'h00, w});
    apb(1'b1, srb_pkg::OFS_CTRL, {30'h0, 1'b1, packet_crc_check});
    n = 0;
    do begin
      apb(1'b0, srb_pkg::OFS_STAT, 32'h0);
      n++;
    end while (rd[srb_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 1000);
    // A frame that never ends counts against the run
    check("frame_done", {31'h0, rd[srb_pkg::STAT_BUSY_BIT]}, 32'h0);
    repeat (4) @(posedge clk_i);
    apb(1'b0, srb_pkg::OFS_RX, 32'h0);
  endtask

  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    $display("[ERR] watchdog expected done seen timeout");
    finish_test();
  end

  initial begin
    reset_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    for (int i = 0; i < srb_pkg::NUM_CH_REGS; i++) begin
      regs[i] = 16'h0F00 + 16'(i) * 16'h0111;
    end
    main_ctrl = 16'h0003;
    {cmode, bfail, ifault, vfault, slew} = 20'h0;
    {otemp, echo, crc_e} = 3'h0;
    checked = 0;
    miscompares = 0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped_rd", rd, 32'h0);
    check("unmapped_err", {31'h0, err_seen}, 32'h1);
    bfail <= 4'hF;
    repeat (4) @(posedge clk_i);
    check("boost_only_pin", {30'h0, fault, fault_oe}, 32'h0);
    check("boost_only_status", {16'h0, status}, {16'h0, exp_st()});
    cmode <= 4'h2;
    bfail <= 4'h6;
    ifault <= 4'h1;
    vfault <= 4'h8;
    slew <= 4'hF;
    otemp <= 1'b1;
    echo <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("status_word", {16'h0, status}, {16'h0, exp_st()});
    check("fault_pin_set", {30'h0, fault, fault_oe}, 32'h1);
    // Ramp flag needs slewing and the channel's enable together
    regs[21][srb_pkg::RAMP_EN_BIT] <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("status_ramp", {31'h0, status[srb_pkg::ST_RAMP]}, 32'h1);
    // Chained requests: each frame returns the one asked before it
    frame(req(ADDR, 5'h00), 1'b0);
    for (int s = 1; s <= 27; s++) begin
      frame(s < 27 ? req(ADDR, 5'(s)) : srb_pkg::NOP_WORD, 1'b0);
      check("readback", {16'h0, rd[15:0]}, {16'h0, exp_reg(s - 1)});
    end
    frame(req(ADDR, 5'h1F), 1'b0);
    frame(srb_pkg::NOP_WORD, 1'b0);
    check("unused_selector", {16'h0, rd[15:0]}, 32'h0);
    frame(req(~ADDR, 5'h08), 1'b0);
    frame(srb_pkg::NOP_WORD, 1'b0);
    check("other_address", {16'h0, rd[15:0]}, 32'h0);
    frame(24'h0A5FFF, 1'b0);
    frame(srb_pkg::NOP_WORD, 1'b0);
    check("write_no_shift", {16'h0, rd[15:0]}, 32'h0);
    check("status_kept", {16'h0, status}, {16'h0, exp_st()});
    main_ctrl <= 16'h0803;
    frame(24'h0A5FFF, 1'b0);
    frame(srb_pkg::NOP_WORD, 1'b0);
    check("autoshift", {16'h0, rd[15:0]}, {16'h0, exp_st()});
    main_ctrl <= 16'h0403;
    frame(srb_pkg::NOP_WORD, 1'b0);
    crc_e = 1'b1;
    check("crc_err_short", {31'h0, crc_err}, 32'h1);
    check("status_crc", {16'h0, status}, {16'h0, exp_st()});
    frame(req(ADDR, 5'h0D), 1'b1);
    crc_e = 1'b0;
    frame(srb_pkg::NOP_WORD, 1'b1);
    check("pec_frame", rd, {srb_pkg::PAD_BYTE, regs[13], tb_crc({srb_pkg::PAD_BYTE, regs[13]})});
    check("crc_err_clear", {31'h0, crc_err}, 32'h0);
    apb(1'b0, srb_pkg::OFS_STAT, 32'h0);
    check("host_crc_ok", {31'h0, rd[srb_pkg::STAT_CRC_BAD_BIT]}, 32'h0);
    finish_test();
  end
endmodule

//--- verif/srb_link_asserts.sv
// Checker on the four link wires between host end and device end.
// Assumes both ends share clk_i and its synchronous reset.
`timescale 1ns/1ps
module srb_link_asserts #(
  parameter int SCLK_HALF = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic sdo
);
  logic [8:0] hi_q;
  logic [5:0] rise_q;
  logic sclk_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Length of each high phase
  always_ff @(posedge clk_i) begin
    hi_q <= (reset_i || !sclk) ? 9'h000 : hi_q + 9'h001;
  end

  always_ff @(posedge clk_i) begin
    sclk_q <= reset_i ? 1'b0 : sclk;
  end

  // Rising edges within one frame
  always_ff @(posedge clk_i) begin
    if (reset_i || sync_n) begin
      rise_q <= 6'h00;
    end else if (sclk && !sclk_q) begin
      rise_q <= rise_q + 6'h01;
    end
  end

  a_sclk_idle_low: assert property (sync_n |-> !sclk)
    else $error("serial clock active outside a frame");
  a_half_period: assert property ($fell(sclk) |-> hi_q == 9'(SCLK_HALF))
    else $error("serial clock high phase has wrong length");
  // Holds for half periods of 5 to 8 clocks only
  a_first_rise: assert property ($fell(sync_n) |-> !sclk [*5] ##[1:4] sclk)
    else $error("first serial clock rise misplaced");
  a_frame_len: assert property ($rose(sync_n) |-> rise_q == 6'h18 || rise_q == 6'h20)
    else $error("frame is neither 24 nor 32 clocks");
  a_sdin_hold: assert property ($fell(sclk) |-> $stable(sdin))
    else $error("host data moved at falling clock");
  a_sdin_launch: assert property ($changed(sdin) && !sync_n && !$fell(sync_n) |-> $rose(sclk))
    else $error("host data moved away from rising clock");
  // Device samples the pins, so its output trails the rise by a few clocks
  a_sdo_launch: assert property ($changed(sdo) && !sync_n |-> hi_q >= 9'h002 && hi_q <= 9'h005)
    else $error("device data moved away from rising clock");
  a_sdo_idle: assert property (sync_n [*8] |-> !sdo)
    else $error("device data not released between frames");

  c_frame24: cover property ($rose(sync_n) && rise_q == 6'h18);
  c_frame32: cover property ($rose(sync_n) && rise_q == 6'h20);
  c_sdo_high: cover property (!sync_n && sdo);
endmodule

//--- verilog/srb_dev_end.sv
// Device end: serial readback decode, output shifter and status word.
// Assumes link pins are asynchronous to clk_i; register images and fault
// sources come from logic on clk_i.
//
// Contract
// - Top bit set means read request
// - Address bits and selector pick register
// - Low sixteen request bits are ignored
// - Host follows read with no-op or read
// - Next frame returns pad byte plus register
// - Output changes rising, host samples falling
// - Packet check appends CRC byte, 32 bits
// - Host keeps clock idle between frames
// - Selectors 0-7 data, control registers
// - Selectors 8-15 gain, offset registers
// - Selectors 16-19 clear-code registers
// - Selectors 20-23 ramp control registers
// - 24 status, 25 main, 26 boost control
// - Status word never written serially
// - Autoshift sends status every write frame
// - Status bit layout fixed
// - Current mode boost flag sets current fault
// - Voltage mode boost flag on regulation loss
// - Boost flags never drive fault pin; here current-mode boost flags do, through the current fault
// - Echo bit follows software register
// - CRC error reflects last received word; here only frames ending while the packet check bit is set update it
// - Ramp active while any channel slews; here only channels with the ramp enable bit set count
`timescale 1ns/1ps
module srb_dev_end (
  input wire logic clk_i,
  input wire logic reset_i,
  srb_link_if.dev link,
  input wire logic [1:0] dev_addr_i,
  input wire logic [srb_pkg::NUM_CH_REGS-1:0][15:0] regs_i,
  input wire logic [15:0] main_ctrl_i,
  input wire logic [15:0] dcdc_ctrl_i,
  input wire logic [3:0] current_mode_i,
  input wire logic [3:0] boost_fail_i,
  input wire logic [3:0] iout_fault_i,
  input wire logic [3:0] vout_fault_i,
  input wire logic [3:0] ramp_slewing_i,
  input wire logic overtemp_i,
  input wire logic user_echo_i,
  output logic [15:0] status_o,
  output logic crc_err_o,
  output logic fault_o,
  output logic fault_oe_o
);
  logic [2:0] sclk_q;
  logic [2:0] sync_n_q;
  logic [1:0] sdin_q;
  logic [1:0] addr_m_q;
  logic [1:0] addr_q;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  logic in_frame;
  logic [31:0] rx_q;
  logic [srb_pkg::CNT_W-1:0] cnt_q;
  logic [31:0] tx_q;
  logic sdo_q;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic crc_err_q;
  logic fault_q;
  logic pec_on;
  logic autoshift_on;
  logic [23:0] word;
  logic frame_ok;
  logic crc_good;
  logic is_read;
  logic [4:0] sel;
  logic [15:0] rd_val;
  logic [3:0] iflt;
  logic [3:0] ramp_live;

  // Pins are asynchronous, two stages before any use
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sclk_q <= 3'h0;
      sync_n_q <= 3'h7;
      sdin_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], link.sclk};
      sync_n_q <= {sync_n_q[1:0], link.sync_n};
      sdin_q <= {sdin_q[0], link.sdin};
    end
  end

  // Address straps resampled every clock after release, resynchronised
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      addr_m_q <= 2'h0;
      addr_q <= 2'h0;
    end else begin
      addr_m_q <= dev_addr_i;
      addr_q <= addr_m_q;
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign frame_start = sync_n_q[2] & ~sync_n_q[1];
  assign frame_end = ~sync_n_q[2] & sync_n_q[1];
  assign in_frame = ~sync_n_q[1];

  assign pec_on = main_ctrl_i[srb_pkg::MAIN_PEC_BIT];
  assign autoshift_on = main_ctrl_i[srb_pkg::MAIN_AUTOSHIFT_BIT];

  // Input bits taken on falling clock edges
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_q <= 32'h00000000;
      cnt_q <= '0;
    end else if (frame_start) begin
      rx_q <= 32'h00000000;
      cnt_q <= '0;
    end else if (in_frame && sclk_fall) begin
      rx_q <= {rx_q[30:0], sdin_q[1]};
      if (cnt_q != {srb_pkg::CNT_W{1'b1}}) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_comb begin
    if (pec_on) begin
      word = rx_q[31:8];
      frame_ok = (cnt_q == srb_pkg::CNT_W'(srb_pkg::PEC_FRAME_BITS));
    end else begin
      word = rx_q[23:0];
      frame_ok = (cnt_q == srb_pkg::CNT_W'(srb_pkg::FRAME_BITS));
    end
  end

  assign crc_good = (srb_pkg::crc8(rx_q[31:8]) == rx_q[7:0]);

  assign is_read = frame_ok && word[srb_pkg::RW_BIT] &&
                   (word[srb_pkg::ADDR_HI_BIT:srb_pkg::ADDR_LO_BIT] == addr_q) &&
                   (!pec_on || crc_good);

  assign sel = word[srb_pkg::SEL_HI_BIT:srb_pkg::SEL_LO_BIT];

  always_comb begin
    rd_val = 16'h0000;
    if (sel < srb_pkg::SEL_STATUS) begin
      rd_val = regs_i[sel];
    end else begin
      case (sel)
        srb_pkg::SEL_STATUS: rd_val = status_q;
        srb_pkg::SEL_MAIN: rd_val = main_ctrl_i;
        srb_pkg::SEL_DCDC: rd_val = dcdc_ctrl_i;
        default: rd_val = 16'h0000;
      endcase
    end
  end

  // Output shifter loaded once per frame end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_q <= 32'h00000000;
      sdo_q <= 1'b0;
    end else if (frame_end) begin
      sdo_q <= 1'b0;
      if (is_read) begin
        tx_q <= {srb_pkg::PAD_BYTE, rd_val, srb_pkg::crc8({srb_pkg::PAD_BYTE, rd_val})};
      end else if (autoshift_on && frame_ok && !word[srb_pkg::RW_BIT]) begin
        tx_q <= {srb_pkg::PAD_BYTE, status_q, srb_pkg::crc8({srb_pkg::PAD_BYTE, status_q})};
      end else begin
        tx_q <= 32'h00000000;
      end
    end else if (in_frame && sclk_rise) begin
      sdo_q <= tx_q[31];
      tx_q <= {tx_q[30:0], 1'b0};
    end
  end

  assign link.sdo = sdo_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      crc_err_q <= 1'b0;
    end else if (frame_end && pec_on) begin
      crc_err_q <= ~(frame_ok & crc_good);
    end
  end

  assign iflt = iout_fault_i | (current_mode_i & boost_fail_i);
  for (genvar c = 0; c < 4; c++) begin : g_ramp
    assign ramp_live[c] = ramp_slewing_i[c] & regs_i[srb_pkg::SEL_RAMP + c][srb_pkg::RAMP_EN_BIT];
  end

  always_comb begin
    status_d = 16'h0000;
    status_d[srb_pkg::ST_BOOST_LO +: 4] = boost_fail_i;
    status_d[srb_pkg::ST_ECHO] = user_echo_i;
    status_d[srb_pkg::ST_CRC_ERR] = crc_err_q;
    status_d[srb_pkg::ST_RAMP] = |ramp_live;
    status_d[srb_pkg::ST_OTEMP] = overtemp_i;
    status_d[srb_pkg::ST_VFLT_LO +: 4] = vout_fault_i;
    status_d[srb_pkg::ST_IFLT_LO +: 4] = iflt;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_q <= srb_pkg::STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= (|iflt) | (|vout_fault_i) | overtemp_i;
    end
  end

  // Open drain: pull low only while a fault stands
  assign fault_o = 1'b0;
  assign fault_oe_o = fault_q;
  assign status_o = status_q;
  assign crc_err_o = crc_err_q;
endmodule

//--- verilog/srb_host_end.sv
// Host end: APB-programmed frame engine driving the serial link.
// Assumes an APB master on clk_i and a device that samples the link pins.
`timescale 1ns/1ps
module srb_host_end #(
  parameter int SCLK_HALF = srb_pkg::SCLK_HALF_DEF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  srb_link_if.host link
);
  typedef enum logic [2:0] {
    SRB_IDLE,
    SRB_LEAD,
    SRB_HIGH,
    SRB_LOW,
    SRB_TRAIL
  } srb_state_e;

  // Device output needs 5 cycles to show through both synchronisers
  if (SCLK_HALF < srb_pkg::SCLK_HALF_MIN || SCLK_HALF > 255) begin : g_chk
    $error("SCLK_HALF out of range");
  end

  srb_state_e state_q;
  logic [7:0] div_q;
  logic [5:0] bit_q;
  logic [5:0] nbits_q;
  logic [31:0] sh_q;
  logic [31:0] rx_q;
  logic [23:0] tx_word_q;
  logic pec_q;
  logic [31:0] prdata_q;
  logic [1:0] sdo_q;
  logic sclk_q;
  logic sync_n_q;
  logic sdin_q;
  logic wr_en;
  logic start;
  logic mapped;
  logic half_done;
  logic start_pec;

  assign mapped = (paddr_i == srb_pkg::OFS_TX) || (paddr_i == srb_pkg::OFS_CTRL) ||
                  (paddr_i == srb_pkg::OFS_STAT) || (paddr_i == srb_pkg::OFS_RX);
  assign wr_en = psel_i && penable_i && pwrite_i && mapped;
  assign start = wr_en && (paddr_i == srb_pkg::OFS_CTRL) && pwdata_i[srb_pkg::CTRL_START_BIT] &&
                 (state_q == SRB_IDLE);
  // Start and check enable share one write, so the frame takes the new bit
  assign start_pec = pwdata_i[srb_pkg::CTRL_PEC_BIT];
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_word_q <= srb_pkg::NOP_WORD;
      pec_q <= 1'b0;
    end else if (wr_en && paddr_i == srb_pkg::OFS_TX) begin
      tx_word_q <= pwdata_i[23:0];
    end else if (wr_en && paddr_i == srb_pkg::OFS_CTRL) begin
      pec_q <= pwdata_i[srb_pkg::CTRL_PEC_BIT];
    end
  end

  // Read data latched in the setup cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_q <= 32'h00000000;
    end else if (psel_i && !penable_i) begin
      prdata_q <= 32'h00000000;
      case (paddr_i)
        srb_pkg::OFS_TX: prdata_q[23:0] <= tx_word_q;
        srb_pkg::OFS_CTRL: prdata_q[srb_pkg::CTRL_PEC_BIT] <= pec_q;
        srb_pkg::OFS_STAT: begin
          prdata_q[srb_pkg::STAT_BUSY_BIT] <= (state_q != SRB_IDLE);
          prdata_q[srb_pkg::STAT_CRC_BAD_BIT] <= pec_q && (srb_pkg::crc8(rx_q[31:8]) != rx_q[7:0]);
        end
        srb_pkg::OFS_RX: prdata_q <= rx_q;
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  assign prdata_o = prdata_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sdo_q <= 2'h0;
    end else begin
      sdo_q <= {sdo_q[0], link.sdo};
    end
  end

  assign half_done = (div_q == 8'(SCLK_HALF - 1));

  always_ff @(posedge clk_i) begin
    if (reset_i || start || half_done) begin
      div_q <= 8'h00;
    end else if (state_q != SRB_IDLE) begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= SRB_IDLE;
      sclk_q <= 1'b0;
      sync_n_q <= 1'b1;
      sdin_q <= 1'b0;
      sh_q <= 32'h00000000;
      rx_q <= 32'h00000000;
      bit_q <= 6'h00;
      nbits_q <= 6'h00;
    end else begin
      case (state_q)
        SRB_IDLE: begin
          if (start) begin
            sync_n_q <= 1'b0;
            rx_q <= 32'h00000000;
            bit_q <= 6'h00;
            sh_q <= {tx_word_q, start_pec ? srb_pkg::crc8(tx_word_q) : srb_pkg::PAD_BYTE};
            nbits_q <= start_pec ? 6'(srb_pkg::PEC_FRAME_BITS) : 6'(srb_pkg::FRAME_BITS);
            state_q <= SRB_LEAD;
          end
        end
        SRB_LEAD, SRB_LOW: begin
          if (half_done) begin
            if (state_q == SRB_LOW && bit_q == nbits_q) begin
              state_q <= SRB_TRAIL;
            end else begin
              sclk_q <= 1'b1;
              sdin_q <= sh_q[31];
              sh_q <= {sh_q[30:0], 1'b0};
              state_q <= SRB_HIGH;
            end
          end
        end
        SRB_HIGH: begin
          if (half_done) begin
            sclk_q <= 1'b0;
            rx_q <= {rx_q[30:0], sdo_q[1]};
            bit_q <= bit_q + 6'h01;
            state_q <= SRB_LOW;
          end
        end
        SRB_TRAIL: begin
          if (half_done) begin
            sync_n_q <= 1'b1;
            state_q <= SRB_IDLE;
          end
        end
        default: state_q <= SRB_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.sync_n = sync_n_q;
  assign link.sdin = sdin_q;
endmodule

//--- verilog/srb_link_if.sv
// Serial link wires between host controller and converter readback logic.
// Assumes the host drives clock, frame select and data in; device drives data out.
`timescale 1ns/1ps
interface srb_link_if;
  logic sclk;
  logic sync_n;
  logic sdin;
  logic sdo;

  modport host (
    output sclk,
    output sync_n,
    output sdin,
    input sdo
  );

  modport dev (
    input sclk,
    input sync_n,
    input sdin,
    output sdo
  );
endinterface

//--- verilog/srb_pkg.sv
// Constants shared by both ends of the serial readback link.
// Assumes both ends run from one 25 MHz clock and sample the link pins.
package srb_pkg;
  localparam int FRAME_BITS = 24;
  localparam int PEC_FRAME_BITS = 32;
  localparam int CRC_W = 8;
  localparam int CNT_W = 6;

  localparam int RW_BIT = 23;
  localparam int ADDR_HI_BIT = 22;
  localparam int ADDR_LO_BIT = 21;
  localparam int SEL_HI_BIT = 20;
  localparam int SEL_LO_BIT = 16;
  localparam logic [23:0] NOP_WORD = 24'h3CE000;

  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // Readback selectors
  localparam int NUM_CH_REGS = 24;
  localparam logic [4:0] SEL_DATA = 5'h00;
  localparam logic [4:0] SEL_CTRL = 5'h04;
  localparam logic [4:0] SEL_GAIN = 5'h08;
  localparam logic [4:0] SEL_OFFS = 5'h0C;
  localparam logic [4:0] SEL_CLR = 5'h10;
  localparam logic [4:0] SEL_RAMP = 5'h14;
  localparam logic [4:0] SEL_STATUS = 5'h18;
  localparam logic [4:0] SEL_MAIN = 5'h19;
  localparam logic [4:0] SEL_DCDC = 5'h1A;

  // Status word layout
  localparam int ST_BOOST_LO = 12;
  localparam int ST_ECHO = 11;
  localparam int ST_CRC_ERR = 10;
  localparam int ST_RAMP = 9;
  localparam int ST_OTEMP = 8;
  localparam int ST_VFLT_LO = 4;
  localparam int ST_IFLT_LO = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  localparam int RAMP_EN_BIT = 12;
  localparam int MAIN_AUTOSHIFT_BIT = 11;
  localparam int MAIN_PEC_BIT = 10;

  // Host register map (APB byte offsets)
  localparam logic [11:0] OFS_TX = 12'h000;
  localparam logic [11:0] OFS_CTRL = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_RX = 12'h00C;
  localparam int CTRL_PEC_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CRC_BAD_BIT = 1;

  localparam real SCLK_PERIOD_NS = 640.0;
  localparam real CLK_PERIOD_NS = 40.0;
  localparam int SCLK_HALF_DEF = int'(SCLK_PERIOD_NS / CLK_PERIOD_NS) / 2;
  localparam int SCLK_HALF_MIN = 6;

  // MSB-first CRC-8 over a 24-bit word
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction
endpackage
